// ==== logic/sdr_pkg.sv ====
// shared constants and state types of the status and diagnostics register block
package sdr_pkg;

  // core clock rate and derived period
  localparam int unsigned CORE_CLK_HZ = 40_000_000;
  localparam int unsigned CORE_CLK_PERIOD_PS = 1_000_000_000 / (CORE_CLK_HZ / 1_000);

  // register map, printed byte offsets (each register spans two bytes)
  localparam logic [6:0] MISC_CONTROL_OFS = 7'h34;
  localparam logic [6:0] ERROR_FLAGS_OFS = 7'h3c;
  localparam logic [15:0] MISC_CONTROL_RST = 16'h0000;
  localparam logic [15:0] ERROR_FLAGS_RST = 16'h0000;

  // misc_control field positions
  localparam int unsigned MC_DR_LINE = 0;
  localparam int unsigned MC_DR_POL = 1;
  localparam int unsigned MC_DR_EN = 2;
  localparam int unsigned MC_ROT_COMP = 6;
  localparam int unsigned MC_LIN_COMP = 7;
  localparam int unsigned MC_EXT_POS = 8;
  localparam int unsigned MC_EXT_NEG = 9;
  localparam int unsigned MC_INT_ST = 10;
  // writable bits of misc_control; unused bits read as zero
  localparam logic [15:0] MISC_CONTROL_WMASK = 16'h07c7;

  // error_flags field positions
  localparam int unsigned EF_SUPPLY_LOW = 0;
  localparam int unsigned EF_SUPPLY_HIGH = 1;
  localparam int unsigned EF_CTRL_FAIL = 2;
  localparam int unsigned EF_LINK_FAIL = 3;
  localparam int unsigned EF_OVER_RANGE = 4;
  localparam int unsigned EF_SELFTEST = 5;
  localparam int unsigned EF_ALARM1 = 8;
  localparam int unsigned EF_ALARM2 = 9;
  localparam int unsigned EF_AXIS_LSB = 10;
  // flags that follow their condition instead of waiting for a read
  localparam logic [15:0] ERROR_FLAGS_LIVE_MASK = 16'h0013;

  // internal self-test duration and external stimulus settling time
  localparam int unsigned SELFTEST_TIME_US = 20_000;
  localparam int unsigned SELFTEST_CYC = SELFTEST_TIME_US * (CORE_CLK_HZ / 1_000_000);
  localparam int unsigned EXT_TAU_NS = 450_000;
  localparam int unsigned EXT_TAU_CYC = (EXT_TAU_NS * 1_000) / CORE_CLK_PERIOD_PS;

  // self-test sequencer states, one-hot
  typedef enum logic [1:0] {
    SDR_ST_IDLE = 2'b01,
    SDR_ST_RUN = 2'b10
  } sdr_st_state_t;

  // core domain state
  typedef struct packed {
    logic [15:0] misc;          // misc_control contents
    logic [15:0] flags;         // error_flags contents
    sdr_st_state_t st;          // self-test sequencer
    logic [31:0] st_cnt;        // self-test cycles left
    logic [31:0] stim_cnt;      // settling cycles left
    logic drdy;                 // raw data-ready pulse
    logic data_valid;           // output data usable
    logic [1:0] dio_out;        // line levels
    logic [1:0] dio_oe;         // line drive enables
    logic req_prev;             // last synced request toggle
    logic ack_tgl;              // answer toggle to link side
    logic [15:0] rdata;         // read answer, held until next request
  } sdr_core_state_t;

  // link domain state
  typedef struct packed {
    logic busy;                 // request outstanding
    logic req_tgl;              // request toggle to core
    logic is_rd;                // held request kind
    logic [6:0] addr;           // held address
    logic [15:0] wdata;         // held write data
    logic ack_prev;             // last synced answer toggle
    logic [15:0] rdata;         // answer data to host
    logic done;                 // answer pulse
  } sdr_link_state_t;

endpackage

// ==== logic/sdr_sync2.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sdr_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_clk,                // destination clock
  input wire logic i_arst_n,             // async reset, active low
  input wire logic [WIDTH-1:0] i_async,  // level from another domain
  output logic [WIDTH-1:0] o_sync        // synchronised level
);
  // first stage is read only by the second stage
  logic [WIDTH-1:0] meta;

  // both stages clear to zero on reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // sdr_sync2

// ==== logic/sdr_status_diag.sv ====
// status and diagnostics register block with link-side register port
// Function
// [RULE1] data-ready on a line, enable/polarity/select bits
// [RULE2] either digital line may carry data-ready
// [RULE3] writing bit 10 starts internal self-test
// [RULE4] self-test failure reported in status bit 5
// [RULE5] self-test lasts 20 ms, output data invalid
// [RULE6] external stimulus bits 9/8 held while set
// [RULE7] rate output settles, 0.45 ms time constant
// [RULE8] bits 7/6 enable the two compensations
// [RULE9] supply and over-range flags clear themselves
// [RULE10] other flags held until status read clears
// [RULE11] bits 15:10 per-axis diagnostic failure flags
// [RULE12] bits 9/8 show alarm two/one active
// [RULE13] bit 4 set on any sensor over-range
// [RULE14] bit 3 link failure, bit 2 update failure
// [RULE15] bit 1 supply high, bit 0 supply low
// [RULE16] line priority: gpio, data-ready, then alarm
// [RULE17] writes to the status register are ignored
// [RULE18] data-ready pulses once per new sample
`timescale 1ns/1ps
module sdr_status_diag #(
  parameter int unsigned SELFTEST_CYCLES = sdr_pkg::SELFTEST_CYC, // self-test length
  parameter int unsigned SETTLE_CYCLES = sdr_pkg::EXT_TAU_CYC     // stimulus settle time
) (
  input wire logic i_core_clk,          // core clock, 40 MHz
  input wire logic i_arst_n,            // async reset, active low
  input wire logic i_link_clk,          // register port clock
  input wire logic i_link_wr,           // write request, link domain
  input wire logic i_link_rd,           // read request, link domain
  input wire logic [6:0] i_link_addr,   // register byte address
  input wire logic [15:0] i_link_wdata, // write data
  output logic o_link_busy,             // request outstanding
  output logic o_link_done,             // answer pulse
  output logic [15:0] o_link_rdata,     // read answer
  input wire logic i_sample_tick,       // new output sample, one cycle
  input wire logic i_mech_fail,         // mechanical check result at end
  input wire logic [5:0] i_axis_fail,   // per-axis diagnostic failure pulses
  input wire logic [1:0] i_alarm_active,// alarm two/one active levels
  input wire logic [5:0] i_over_range,  // per-sensor over-range levels
  input wire logic i_supply_high,       // supply above upper limit, async
  input wire logic i_supply_low,        // supply below lower limit, async
  input wire logic i_link_fail,         // serial transfer failure pulse
  input wire logic i_ctrl_fail,         // control update failure pulse
  input wire logic [1:0] i_gpio_dir,    // gpio output enables
  input wire logic [1:0] i_gpio_level,  // gpio output levels
  input wire logic i_alarm_out_en,      // alarm drives a line
  input wire logic i_alarm_out_pol,     // alarm line active high
  input wire logic i_alarm_out_sel,     // alarm line select
  input wire logic [1:0] i_dio_in,      // digital line pin levels
  output logic [1:0] o_dio_out,         // digital line drive levels
  output logic [1:0] o_dio_oe,          // digital line drive enables
  output logic [1:0] o_dio_in_sync,     // synchronised pin levels
  output logic o_selftest_run,          // internal self-test active
  output logic o_data_valid,            // output data usable
  output logic o_ext_pos_stim,          // positive rotation stimulus
  output logic o_ext_neg_stim,          // negative rotation stimulus
  output logic o_stim_settling,         // rate output still settling
  output logic o_lin_accel_comp,        // gyro linear accel compensation
  output logic o_rot_comp               // accel rotational compensation
);

  // refuse counts the counters cannot serve
  if (SELFTEST_CYCLES < 1 || SETTLE_CYCLES < 1) begin : g_bad_param
    $error("sdr_status_diag: cycle counts must be at least one");
  end

  // word address of a byte address, both bytes of a register decode alike
  function automatic logic hits(input logic [6:0] addr, input logic [6:0] ofs);
    hits = (addr[6:1] == ofs[6:1]);
  endfunction

  sdr_pkg::sdr_core_state_t c;      // core state
  sdr_pkg::sdr_core_state_t next_c; // core next state
  sdr_pkg::sdr_link_state_t l;      // link state
  sdr_pkg::sdr_link_state_t next_l; // link next state
  logic req_sync;                   // request toggle in core domain
  logic ack_sync;                   // answer toggle in link domain
  logic [3:0] pin_sync;             // supply comparators and dio pins

  // request toggle crosses into the core domain
  sdr_sync2 #(.WIDTH(1)) u_req_sync (
    .i_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_async(l.req_tgl),
    .o_sync(req_sync)
  );

  // answer toggle crosses back into the link domain
  sdr_sync2 #(.WIDTH(1)) u_ack_sync (
    .i_clk(i_link_clk),
    .i_arst_n(i_arst_n),
    .i_async(c.ack_tgl),
    .o_sync(ack_sync)
  );

  // pins and analog comparators are asynchronous to the core
  sdr_sync2 #(.WIDTH(4)) u_pin_sync (
    .i_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_async({i_dio_in, i_supply_high, i_supply_low}),
    .o_sync(pin_sync)
  );

  // link side: take one request at a time, hold it until the core answers
  always_comb begin
    logic ack_edge;
    ack_edge = 1'b0;
    next_l = l;
    ack_edge = ack_sync ^ l.ack_prev;
    next_l.ack_prev = ack_sync;
    next_l.done = 1'b0;
    if (ack_edge) begin
      // core holds rdata stable until the next request, safe to copy
      next_l.busy = 1'b0;
      next_l.done = 1'b1;
      next_l.rdata = c.rdata;
    end
    if (!l.busy && (i_link_wr || i_link_rd)) begin
      // read wins when both strobes come together
      next_l.busy = 1'b1;
      next_l.req_tgl = ~l.req_tgl;
      next_l.is_rd = i_link_rd;
      next_l.addr = i_link_addr;
      next_l.wdata = i_link_wdata;
    end
  end

  // link state register
  always_ff @(posedge i_link_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // core side: register access, flags, self-test, line routing
  always_comb begin
    logic req_edge;
    logic do_rd;
    logic do_wr;
    logic rd_clear;
    logic st_done;
    logic ctrl_refused;
    logic [15:0] set_v;
    logic [15:0] live_v;
    logic dr_level;
    logic al_level;
    req_edge = 1'b0;
    do_rd = 1'b0;
    do_wr = 1'b0;
    rd_clear = 1'b0;
    st_done = 1'b0;
    ctrl_refused = 1'b0;
    set_v = '0;
    live_v = '0;
    dr_level = 1'b0;
    al_level = 1'b0;
    next_c = c;

    // a toggle change marks a new request; its fields are held stable
    req_edge = req_sync ^ c.req_prev;
    next_c.req_prev = req_sync;
    do_rd = req_edge & l.is_rd;
    do_wr = req_edge & ~l.is_rd;

    // reads: status read clears the sticky flags, unmapped reads give zero
    if (do_rd) begin
      next_c.ack_tgl = ~c.ack_tgl;
      if (hits(l.addr, sdr_pkg::MISC_CONTROL_OFS)) begin
        next_c.rdata = c.misc;
      end else if (hits(l.addr, sdr_pkg::ERROR_FLAGS_OFS)) begin
        next_c.rdata = c.flags;
        rd_clear = 1'b1; // RULE10
      end else begin
        next_c.rdata = '0;
      end
    end

    // writes: only misc_control takes data; status writes fall away
    if (do_wr) begin
      next_c.ack_tgl = ~c.ack_tgl;
      if (hits(l.addr, sdr_pkg::MISC_CONTROL_OFS)) begin
        if (c.st == sdr_pkg::SDR_ST_RUN) begin
          // changing control mid self-test would corrupt the check
          ctrl_refused = 1'b1; // RULE14
        end else begin
          next_c.misc = l.wdata & sdr_pkg::MISC_CONTROL_WMASK; // RULE6 RULE8
        end
      end
      // error_flags and unmapped addresses are left untouched
      // RULE17
    end

    // stimulus change restarts the settling window
    if (next_c.misc[sdr_pkg::MC_EXT_NEG:sdr_pkg::MC_EXT_POS] !=
        c.misc[sdr_pkg::MC_EXT_NEG:sdr_pkg::MC_EXT_POS]) begin
      next_c.stim_cnt = SETTLE_CYCLES; // RULE7
    end else if (c.stim_cnt != 32'h0000_0000) begin
      next_c.stim_cnt = c.stim_cnt - 32'h0000_0001;
    end

    // self-test sequencer
    unique case (c.st)
      sdr_pkg::SDR_ST_IDLE: begin
        if (next_c.misc[sdr_pkg::MC_INT_ST]) begin
          next_c.st = sdr_pkg::SDR_ST_RUN; // RULE3
          next_c.st_cnt = SELFTEST_CYCLES - 1; // RULE5
        end
      end
      sdr_pkg::SDR_ST_RUN: begin
        if (c.st_cnt == 32'h0000_0000) begin
          // start bit clears itself so software can poll it
          st_done = 1'b1;
          next_c.st = sdr_pkg::SDR_ST_IDLE;
          next_c.misc[sdr_pkg::MC_INT_ST] = 1'b0;
        end else begin
          next_c.st_cnt = c.st_cnt - 32'h0000_0001;
        end
      end
    endcase

    // sticky events
    set_v[sdr_pkg::EF_AXIS_LSB +: 6] = i_axis_fail; // RULE11
    set_v[sdr_pkg::EF_ALARM1] = i_alarm_active[0]; // RULE12
    set_v[sdr_pkg::EF_ALARM2] = i_alarm_active[1]; // RULE12
    set_v[sdr_pkg::EF_SELFTEST] = st_done & i_mech_fail; // RULE4
    set_v[sdr_pkg::EF_LINK_FAIL] = i_link_fail; // RULE14
    set_v[sdr_pkg::EF_CTRL_FAIL] = i_ctrl_fail | ctrl_refused; // RULE14
    // live conditions
    live_v[sdr_pkg::EF_OVER_RANGE] = |i_over_range; // RULE13
    live_v[sdr_pkg::EF_SUPPLY_HIGH] = pin_sync[1]; // RULE15
    live_v[sdr_pkg::EF_SUPPLY_LOW] = pin_sync[0]; // RULE15

    // live flags follow their condition; sticky ones clear on read, set wins
    next_c.flags = (c.flags & ~sdr_pkg::ERROR_FLAGS_LIVE_MASK & {16{~rd_clear}})
                   | set_v | live_v; // RULE9 RULE10

    // one pulse per sample, none while self-test makes data invalid
    next_c.data_valid = (next_c.st == sdr_pkg::SDR_ST_IDLE); // RULE5
    next_c.drdy = i_sample_tick & next_c.misc[sdr_pkg::MC_DR_EN]
                  & next_c.data_valid; // RULE18

    // active levels of data-ready and alarm on their lines
    dr_level = next_c.misc[sdr_pkg::MC_DR_POL] ? next_c.drdy : ~next_c.drdy; // RULE1
    al_level = i_alarm_out_pol ? (|i_alarm_active) : ~(|i_alarm_active);

    // per-line priority routing
    for (int n = 0; n < 2; n++) begin
      if (i_gpio_dir[n]) begin
        next_c.dio_out[n] = i_gpio_level[n]; // RULE16
        next_c.dio_oe[n] = 1'b1;
      end else if (next_c.misc[sdr_pkg::MC_DR_EN] &&
                   (next_c.misc[sdr_pkg::MC_DR_LINE] == n[0])) begin
        next_c.dio_out[n] = dr_level; // RULE1 RULE2
        next_c.dio_oe[n] = 1'b1;
      end else if (i_alarm_out_en && (i_alarm_out_sel == n[0])) begin
        next_c.dio_out[n] = al_level; // RULE16
        next_c.dio_oe[n] = 1'b1;
      end else begin
        // line left to its input role
        next_c.dio_out[n] = 1'b0;
        next_c.dio_oe[n] = 1'b0;
      end
    end
  end

  // core state register
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      c.misc <= sdr_pkg::MISC_CONTROL_RST;
      c.flags <= sdr_pkg::ERROR_FLAGS_RST;
      c.st <= sdr_pkg::SDR_ST_IDLE;
      c.st_cnt <= '0;
      c.stim_cnt <= '0;
      c.drdy <= 1'b0;
      c.data_valid <= 1'b1;
      c.dio_out <= '0;
      c.dio_oe <= '0;
      c.req_prev <= 1'b0;
      c.ack_tgl <= 1'b0;
      c.rdata <= '0;
    end else begin
      c <= next_c;
    end
  end

  // outputs straight from state
  assign o_link_busy = l.busy;
  assign o_link_done = l.done;
  assign o_link_rdata = l.rdata;
  assign o_dio_out = c.dio_out;
  assign o_dio_oe = c.dio_oe;
  assign o_dio_in_sync = pin_sync[3:2];
  assign o_selftest_run = (c.st == sdr_pkg::SDR_ST_RUN); // RULE3
  assign o_data_valid = c.data_valid; // RULE5
  assign o_ext_pos_stim = c.misc[sdr_pkg::MC_EXT_POS]; // RULE6
  assign o_ext_neg_stim = c.misc[sdr_pkg::MC_EXT_NEG]; // RULE6
  assign o_stim_settling = (c.stim_cnt != 32'h0000_0000); // RULE7
  assign o_lin_accel_comp = c.misc[sdr_pkg::MC_LIN_COMP]; // RULE8
  assign o_rot_comp = c.misc[sdr_pkg::MC_ROT_COMP]; // RULE8

endmodule // sdr_status_diag

// ==== tb/sdr_properties.sv ====
// port checks of the status and diagnostics block
`timescale 1ns/1ps
module sdr_properties #(
  parameter int unsigned SELFTEST_CYCLES = 20, // self-test length
  parameter int unsigned SETTLE_CYCLES = 5 // settle length
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_arst_n, // reset, active low
  input wire logic i_link_clk, // port clock
  input wire logic i_link_wr, // write request
  input wire logic i_link_rd, // read request
  input wire logic o_link_busy, // outstanding
  input wire logic o_link_done, // answer pulse
  input wire logic [1:0] i_gpio_dir, // gpio enables
  input wire logic [1:0] i_gpio_level, // gpio levels
  input wire logic [1:0] i_dio_in, // pin levels
  input wire logic [1:0] o_dio_out, // line levels
  input wire logic [1:0] o_dio_oe, // line enables
  input wire logic [1:0] o_dio_in_sync, // synced pins
  input wire logic o_selftest_run, // self-test active
  input wire logic o_data_valid, // data usable
  input wire logic o_stim_settling // settling
);
  logic [31:0] run_cnt; // self-test cycles seen
  logic [31:0] set_cnt; // settle cycles seen
  // counters restart whenever their level drops
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_cnt <= '0;
      set_cnt <= '0;
    end else begin
      run_cnt <= o_selftest_run ? run_cnt + 32'h0000_0001 : '0;
      set_cnt <= o_stim_settling ? set_cnt + 32'h0000_0001 : '0;
    end
  end
  run_len_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $fell(o_selftest_run) |-> run_cnt == SELFTEST_CYCLES) else $error("self-test length");
  run_cap_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    run_cnt <= SELFTEST_CYCLES) else $error("self-test overrun");
  valid_off_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_data_valid != o_selftest_run) else $error("data valid during self-test");
  settle_len_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $fell(o_stim_settling) |-> set_cnt == SETTLE_CYCLES) else $error("settle length");
  gpio_first_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_gpio_dir[0] |=> o_dio_oe[0] && o_dio_out[0] == $past(i_gpio_level[0]))
    else $error("gpio lost priority");
  pin_sync_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $past(i_arst_n, 2) |-> o_dio_in_sync == $past(i_dio_in, 2)) else $error("pin sync");
  take_busy_a: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
    (i_link_wr || i_link_rd) && !o_link_busy |=> o_link_busy) else $error("request lost");
  answer_due_a: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
    $rose(o_link_busy) |-> ##[1:8] o_link_done) else $error("answer late");
  done_pulse_a: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
    o_link_done |-> !o_link_busy ##1 !o_link_done) else $error("done shape");
  cover property (@(posedge i_core_clk) $fell(o_selftest_run));
  cover property (@(posedge i_core_clk) $fell(o_stim_settling));
  cover property (@(posedge i_link_clk) o_link_done);
endmodule // sdr_properties

bind sdr_status_diag sdr_properties #(
  .SELFTEST_CYCLES(SELFTEST_CYCLES),
  .SETTLE_CYCLES(SETTLE_CYCLES)
) i_sdr_properties (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_link_clk(i_link_clk),
  .i_link_wr(i_link_wr), .i_link_rd(i_link_rd), .o_link_busy(o_link_busy),
  .o_link_done(o_link_done), .i_gpio_dir(i_gpio_dir), .i_gpio_level(i_gpio_level),
  .i_dio_in(i_dio_in), .o_dio_out(o_dio_out), .o_dio_oe(o_dio_oe),
  .o_dio_in_sync(o_dio_in_sync), .o_selftest_run(o_selftest_run),
  .o_data_valid(o_data_valid), .o_stim_settling(o_stim_settling)
);

// ==== tb/sdr_host_model.sv ====
// host model driving the register port
`timescale 1ns/1ps
module sdr_host_model (
  input wire logic i_link_clk, // port clock
  output logic o_link_wr, // write request
  output logic o_link_rd, // read request
  output logic [6:0] o_link_addr, // byte address
  output logic [15:0] o_link_wdata, // write data
  input wire logic i_link_busy, // outstanding
  input wire logic i_link_done, // answer pulse
  input wire logic [15:0] i_link_rdata // answer data
);
  initial begin
    o_link_wr = 1'b0;
    o_link_rd = 1'b0;
    o_link_addr = 7'h00;
    o_link_wdata = 16'h0000;
  end
  // one transfer; gap idles first so requests come both back to back and spaced apart
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] wd,
                      input int gap, output logic [15:0] q);
    int n;
    repeat (gap) @(posedge i_link_clk);
    @(posedge i_link_clk);
    o_link_rd <= rd;
    o_link_wr <= !rd;
    o_link_addr <= a;
    o_link_wdata <= wd;
    n = 0;
    // held until an edge sees the port free
    do begin
      @(posedge i_link_clk);
      n++;
    end while (i_link_busy && n < 16);
    o_link_rd <= 1'b0;
    o_link_wr <= 1'b0;
    // released lines show the inverse, never a stale copy
    o_link_addr <= ~a;
    o_link_wdata <= ~wd;
    n = 0;
    do begin
      @(posedge i_link_clk);
      n++;
    end while (!i_link_done && n < 16);
    q = i_link_done ? i_link_rdata : 16'hxxxx;
  endtask
endmodule // sdr_host_model

// ==== tb/sdr_status_diag_bench.sv ====
// self-checking bench of the status and diagnostics block
`timescale 1ns/1ps
module sdr_status_diag_bench;
  localparam int ST = 200; // shortened self-test
  localparam int SC = 5; // shortened settle
  logic clk = 1'b0, lclk = 1'b0, arst_n = 1'b0, wr, rd, busy, done;
  logic [6:0] addr;
  logic [15:0] wdata, rdata, q, d, e;
  logic tick = 1'b0, mech = 1'b0, shi = 1'b0, slo = 1'b0, lf = 1'b0, cf = 1'b0;
  logic [5:0] axf = 6'h00, ovr = 6'h00;
  logic [1:0] alm = 2'h0, gdir = 2'h0, glev = 2'h0, din = 2'h0, dout, doe, dsync;
  logic run, dval, pos, neg, sett, lin, rot, ln, pl, gp;
  int n_mismatch = 0, cmp_count = 0, seed = 32'h332c, cyc = 0, rlen = 0, last = 0, act, n;
  sdr_status_diag #(.SELFTEST_CYCLES(ST), .SETTLE_CYCLES(SC)) i_sdr_status_diag (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_link_clk(lclk), .i_link_wr(wr),
    .i_link_rd(rd), .i_link_addr(addr), .i_link_wdata(wdata), .o_link_busy(busy),
    .o_link_done(done), .o_link_rdata(rdata), .i_sample_tick(tick), .i_mech_fail(mech),
    .i_axis_fail(axf), .i_alarm_active(alm), .i_over_range(ovr), .i_supply_high(shi),
    .i_supply_low(slo), .i_link_fail(lf), .i_ctrl_fail(cf), .i_gpio_dir(gdir),
    .i_gpio_level(glev), .i_alarm_out_en(1'b0), .i_alarm_out_pol(1'b0),
    .i_alarm_out_sel(1'b0), .i_dio_in(din), .o_dio_out(dout), .o_dio_oe(doe),
    .o_dio_in_sync(dsync), .o_selftest_run(run), .o_data_valid(dval),
    .o_ext_pos_stim(pos), .o_ext_neg_stim(neg), .o_stim_settling(sett),
    .o_lin_accel_comp(lin), .o_rot_comp(rot));
  sdr_host_model i_sdr_host_model (
    .i_link_clk(lclk), .o_link_wr(wr), .o_link_rd(rd), .o_link_addr(addr),
    .o_link_wdata(wdata), .i_link_busy(busy), .i_link_done(done), .i_link_rdata(rdata));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // link clock, phase unrelated to the core clock
  initial begin
    #7;
    forever begin
      lclk = ~lclk;
      #40;
    end
  end
  // watchdog, self-test length meter and random pin levels
  always @(posedge clk) begin
    din <= 2'($random(seed));
    cyc++;
    if (run) rlen++;
    else if (rlen != 0) begin
      last = rlen;
      rlen = 0;
    end
    if (cyc == 40000) begin
      n_mismatch++;
      $display("unexpected at %0t: run hung", $time);
      give_verdict();
    end
  end
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %b want %b", $time, s, got, exp);
    end
  endtask
  task automatic wreg(input logic [6:0] a, input logic [15:0] v);
    i_sdr_host_model.xfer(1'b0, a, v, $random(seed) & 3, q);
  endtask
  task automatic rreg(input logic [6:0] a, input logic [15:0] v, input string s);
    i_sdr_host_model.xfer(1'b1, a, v, $random(seed) & 3, q);
    chk16(q, v, s);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge lclk);
    rreg(7'h34, 16'h0000, "control reset");
    rreg(7'h3c, 16'h0000, "flags reset");
    $display("test reset done");
    // random control values, start bit kept clear, odd byte address too
    for (int i = 0; i < 6; i++) begin
      d = 16'($random(seed)) & 16'hfbff;
      wreg(i[0] ? 7'h35 : 7'h34, d);
      e = d & sdr_pkg::MISC_CONTROL_WMASK;
      rreg(7'h34, e, "control readback");
      chk1(pos, e[8], "positive stimulus");
      chk1(neg, e[9], "negative stimulus");
      chk1(lin, e[7], "linear compensation");
      chk1(rot, e[6], "rotational compensation");
    end
    wreg(7'h20, 16'hffff);
    rreg(7'h20, 16'h0000, "unmapped read");
    rreg(7'h34, e, "control kept");
    wreg(7'h3c, 16'hffff);
    rreg(7'h3c, 16'h0000, "flags not writable");
    $display("test registers done");
    // sticky events, pulsed once, must survive until one read clears them
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      d = 16'($random(seed));
      axf <= d[15:10];
      alm <= d[9:8];
      lf <= i[0];
      cf <= i[1];
      @(posedge clk);
      axf <= 6'h00;
      alm <= 2'h0;
      lf <= 1'b0;
      cf <= 1'b0;
      e = {d[15:8], 4'h0, i[0], i[1], 2'h0};
      rreg(7'h3c, e, "sticky flags");
      rreg(7'h3c, 16'h0000, "flags after read");
    end
    $display("test sticky done");
    @(posedge clk);
    ovr <= 6'h20;
    shi <= 1'b1;
    repeat (6) @(posedge clk);
    rreg(7'h3c, 16'h0012, "over-range and supply high");
    rreg(7'h3c, 16'h0012, "live flags survive read");
    @(posedge clk);
    ovr <= 6'h00;
    shi <= 1'b0;
    slo <= 1'b1;
    repeat (6) @(posedge clk);
    rreg(7'h3c, 16'h0001, "supply low");
    @(posedge clk);
    slo <= 1'b0;
    repeat (6) @(posedge clk);
    rreg(7'h3c, 16'h0000, "live flags gone");
    $display("test live done");
    // every line, polarity, and gpio override of the data-ready pulse
    for (int k = 0; k < 8; k++) begin
      ln = k[0];
      pl = k[1];
      gp = k[2];
      wreg(7'h34, {13'h0000, 1'b1, pl, ln});
      @(posedge clk);
      gdir <= gp ? (2'h1 << ln) : 2'h0;
      glev <= {2{~pl}};
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      act = 0;
      repeat (5) begin
        @(negedge clk);
        if (dout[ln] === pl) act++;
      end
      chk16(16'(act), gp ? 16'h0000 : 16'h0001, "active cycles");
      chk1(doe[ln], 1'b1, "line driven");
      chk1(doe[!ln], 1'b0, "other line free");
    end
    @(posedge clk);
    gdir <= 2'h0;
    $display("test data-ready done");
    for (int f = 1; f >= 0; f--) begin
      @(posedge clk);
      mech <= f[0];
      wreg(7'h34, 16'h0400);
      rreg(7'h34, 16'h0400, "start bit while running");
      wreg(7'h34, 16'h0040);
      n = 0;
      while (run && n < 400) begin
        @(posedge clk);
        n++;
      end
      repeat (2) @(posedge clk);
      chk16(16'(last), 16'(ST), "self-test length");
      rreg(7'h34, 16'h0000, "start bit cleared");
      rreg(7'h3c, {10'h000, f[0], 5'h04}, "self-test result");
    end
    $display("test self-test done");
    give_verdict();
  end
endmodule // sdr_status_diag_bench
